// File: rtl/cmb_cfg.svh
/*
 * Address map, field positions and fixed figures of the mailbox store.
 * Assumes inclusion by its bare name.
 */
`ifndef CMB_CFG_SVH
`define CMB_CFG_SVH

// mailbox count and index widths
`define CMB_MBX_COUNT 16
`define CMB_MBX_BITS 4
`define CMB_IDX_BITS 8
`define CMB_BYTES_PER_MBX 16

// byte slots in a mailbox: control bytes, then payload
`define CMB_SLOT_LEN 0
`define CMB_SLOT_SPARE_A 1
`define CMB_SLOT_SPARE_B 2
`define CMB_SLOT_SPARE_C 3
`define CMB_SLOT_FMT 4
`define CMB_SLOT_ID_TOP 5
`define CMB_SLOT_ID_LOW 6
`define CMB_SLOT_ID_LMID 7
`define CMB_SLOT_DATA 8

// bus byte addresses, one byte per aligned word
`define CMB_MBX_STRIDE 32'h0000_0040
`define CMB_CTRL_OFS 32'h0000_0000
`define CMB_DATA_OFS 32'h0000_0020
`define CMB_MAP_TOP_LSB 10
`define CMB_WORD_LSB 2

// field positions and values
`define CMB_DLC_MAX 4'h8
`define CMB_RTR_BIT 4
`define CMB_IDE_BIT 3
`define CMB_SPARE_BIT 2
`define CMB_ID_W 29
`define CMB_LEN_MASK 8'h0F
`define CMB_FMT_MASK 8'hFB
`define CMB_FULL_MASK 8'hFF
`define CMB_NO_MASK 8'h00
`define CMB_STD_ID_LSB 18

// bus answers
`define CMB_RESP_OKAY 2'b00
`define CMB_RESP_SLVERR 2'b10

`endif

// File: rtl/cmb_pkg.sv
/*
 * Types and field functions of the mailbox store.
 * Assumes cmb_cfg.svh on the include path.
 */
`include "cmb_cfg.svh"

package cmb_pkg;

    typedef logic [`CMB_MBX_BITS-1:0] cmb_mbx_t;
    typedef logic [`CMB_IDX_BITS-1:0] cmb_idx_t;
    typedef logic [7:0] cmb_byte_t;
    typedef logic [3:0] cmb_len_t;
    typedef logic [`CMB_ID_W-1:0] cmb_id_t;
    typedef logic [63:0] cmb_payload_t;
    typedef logic [`CMB_BYTES_PER_MBX*8-1:0] cmb_bytes_t;

    typedef enum logic [1:0] {CMB_W_IDLE, CMB_W_STORE, CMB_W_RESP} cmb_wr_state_t;
    typedef enum logic [1:0] {CMB_R_IDLE, CMB_R_WAIT, CMB_R_FETCH, CMB_R_RESP} cmb_rd_state_t;

    typedef struct packed {
        cmb_wr_state_t wst;
        cmb_rd_state_t rst;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [31:0] waddr;
        cmb_byte_t wbyte;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] raddr;
        cmb_mbx_t eng_mbx;
        logic eng_p1;
        logic eng_p2;
        logic eng_rd_valid;
        cmb_len_t eng_rd_len;
        logic eng_rd_rtr;
        logic eng_rd_ide;
        cmb_id_t eng_rd_id;
        cmb_payload_t eng_rd_data;
    } cmb_state_t;

    // codes above eight still mean eight payload bytes
    function automatic cmb_len_t cmb_eff_len(input cmb_len_t code);
        cmb_eff_len = (code > `CMB_DLC_MAX) ? `CMB_DLC_MAX : code;
    endfunction : cmb_eff_len

    // byte of slot n out of a whole mailbox image
    function automatic cmb_byte_t cmb_slot(input cmb_bytes_t img, input int n);
        cmb_slot = img[n*8 +: 8];
    endfunction : cmb_slot

endpackage : cmb_pkg

// File: rtl/cmb_store_if.sv
/*
 * Link from the front end to the mailbox byte array.
 * Assumes one clock; array reads are registered.
 */
`timescale 1ns/10ps

interface cmb_store_if;
    import cmb_pkg::*;

    logic cpu_we;
    cmb_idx_t cpu_widx;
    cmb_byte_t cpu_wdata;
    cmb_idx_t cpu_ridx;
    cmb_byte_t cpu_rdata;
    logic eng_we;
    cmb_mbx_t eng_widx;
    cmb_bytes_t eng_wmask;
    cmb_bytes_t eng_wbytes;
    cmb_mbx_t eng_ridx;
    cmb_bytes_t eng_rbytes;

    modport store (
        input cpu_we, cpu_widx, cpu_wdata, cpu_ridx, eng_we, eng_widx, eng_wmask, eng_wbytes,
        input eng_ridx,
        output cpu_rdata, eng_rbytes
    );
    modport user (
        output cpu_we, cpu_widx, cpu_wdata, cpu_ridx, eng_we, eng_widx, eng_wmask, eng_wbytes,
        output eng_ridx,
        input cpu_rdata, eng_rbytes
    );

endinterface : cmb_store_if

// File: rtl/cmb_msg_store.sv
/*
 * Mailbox byte array: control and payload bytes of every mailbox.
 * Assumes the user never writes from both ports in one cycle.
 */
`timescale 1ns/10ps

module cmb_msg_store #(
    parameter int MBX_N = `CMB_MBX_COUNT
) (
    input wire logic aclk,
    cmb_store_if.store sp
);
    import cmb_pkg::*;

    // plain ram: no reset, content undefined until software writes it
    cmb_byte_t mem [0:MBX_N*`CMB_BYTES_PER_MBX-1];

    ////////////////////////////////////////////////////////////////////////////
    // writes: one cpu byte, or a masked mailbox image from the engine
    always_ff @(posedge aclk)
    begin
        if (sp.cpu_we)
        begin
            mem[sp.cpu_widx] <= sp.cpu_wdata;
        end
        if (sp.eng_we)
        begin
            for (int b = 0; b < `CMB_BYTES_PER_MBX; b++)
            begin
                mem[{sp.eng_widx, 4'(b)}] <= (mem[{sp.eng_widx, 4'(b)}] & ~sp.eng_wmask[b*8 +: 8])
                    | (sp.eng_wbytes[b*8 +: 8] & sp.eng_wmask[b*8 +: 8]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered reads for both ports
    always_ff @(posedge aclk)
    begin
        sp.cpu_rdata <= mem[sp.cpu_ridx];
        for (int b = 0; b < `CMB_BYTES_PER_MBX; b++)
        begin
            sp.eng_rbytes[b*8 +: 8] <= mem[{sp.eng_ridx, 4'(b)}];
        end
    end

endmodule : cmb_msg_store

// File: rtl/cmb_mailbox_ram.sv
/*
 * Mailbox message storage with an AXI4-Lite port and a protocol
 * engine port that moves whole mailboxes.
 * Assumes the engine signals are on aclk; bus master keeps AXI4-Lite rules.
 */
// Register access over AXI4-Lite and the address map were decided locally.
//
// Behaviour
// - length code in low nibble, above eight means eight
// - fifth control byte bit 4 selects remote frame
// - fifth control byte bit 3 selects extended format
// - fifth byte bits 7:5 hold identifier 20:18
// - fifth byte bits 1:0 hold identifier 17:16
// - sixth byte holds identifier 28:21
// - seventh byte holds identifier 7:0
// - eighth byte holds identifier 15:8
// - spare control bits are plain read/write storage
// - fifth byte bit 2 is plain storage
// - eight addressable payload bytes per mailbox
// - sixteen mailboxes, each with own bytes
// - payload storage is uninitialised ram
// - eight control bytes per mailbox
// - reset leaves mailbox storage untouched
`timescale 1ns/10ps

module cmb_mailbox_ram #(
    parameter int MBX_N = `CMB_MBX_COUNT
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // protocol engine: fetch a mailbox for sending
    input wire logic eng_rd_req,
    input wire cmb_pkg::cmb_mbx_t eng_rd_mbx,
    output logic eng_rd_valid,
    output cmb_pkg::cmb_len_t eng_rd_len,
    output logic eng_rd_rtr,
    output logic eng_rd_ide,
    output cmb_pkg::cmb_id_t eng_rd_id,
    output cmb_pkg::cmb_payload_t eng_rd_data,
    // protocol engine: store a received frame
    input wire logic eng_wr_en,
    input wire cmb_pkg::cmb_mbx_t eng_wr_mbx,
    input wire cmb_pkg::cmb_len_t eng_wr_dlc,
    input wire logic eng_wr_rtr,
    input wire logic eng_wr_ide,
    input wire cmb_pkg::cmb_id_t eng_wr_id,
    input wire cmb_pkg::cmb_payload_t eng_wr_data
);
    import cmb_pkg::*;

    cmb_state_t s;
    cmb_state_t next_s;
    cmb_store_if sp ();
    logic waddr_ok;
    logic raddr_ok;
    cmb_bytes_t img;
    cmb_len_t img_code;
    cmb_byte_t img_fmt;
    cmb_id_t img_id;

    ////////////////////////////////////////////////////////////////////////////
    // byte array; no reset port, so a reset cannot disturb it
    cmb_msg_store #(
        .MBX_N(MBX_N)
    ) u_store (
        .aclk(aclk),
        .sp(sp.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode: only the low 1 KiB is mapped; prot is ignored
    assign waddr_ok = (s.waddr[31:`CMB_MAP_TOP_LSB] == '0);
    assign raddr_ok = (s.raddr[31:`CMB_MAP_TOP_LSB] == '0);

    // word index = {mailbox, slot}, one word per slot
    assign sp.cpu_widx = s.waddr[`CMB_MAP_TOP_LSB-1:`CMB_WORD_LSB];
    assign sp.cpu_ridx = s.raddr[`CMB_MAP_TOP_LSB-1:`CMB_WORD_LSB];
    assign sp.cpu_wdata = s.wbyte;

    // the engine wins the array; a pending bus write waits while eng_wr_en is high
    assign sp.cpu_we = (s.wst == CMB_W_STORE) && !eng_wr_en && waddr_ok && s.wlane;

    ////////////////////////////////////////////////////////////////////////////
    // engine write image: fields land on their fixed bit positions
    always_comb
    begin
        sp.eng_we = eng_wr_en;
        sp.eng_widx = eng_wr_mbx;
        sp.eng_wbytes = '0;
        sp.eng_wmask = '0;
        // length code in the low nibble; upper nibble kept
        sp.eng_wbytes[`CMB_SLOT_LEN*8 +: 8] = {4'h0, eng_wr_dlc};
        sp.eng_wmask[`CMB_SLOT_LEN*8 +: 8] = `CMB_LEN_MASK;
        // spare bytes two to four are left alone
        sp.eng_wmask[`CMB_SLOT_SPARE_A*8 +: 8] = `CMB_NO_MASK;
        sp.eng_wmask[`CMB_SLOT_SPARE_B*8 +: 8] = `CMB_NO_MASK;
        sp.eng_wmask[`CMB_SLOT_SPARE_C*8 +: 8] = `CMB_NO_MASK;
        // fifth byte: id 20:18, frame type, format, spare, id 17:16
        sp.eng_wbytes[`CMB_SLOT_FMT*8 +: 8] = {eng_wr_id[20:18], eng_wr_rtr, eng_wr_ide, 1'b0,
            eng_wr_id[17:16]};
        sp.eng_wmask[`CMB_SLOT_FMT*8 +: 8] = `CMB_FMT_MASK;
        sp.eng_wbytes[`CMB_SLOT_ID_TOP*8 +: 8] = eng_wr_id[28:21];
        sp.eng_wmask[`CMB_SLOT_ID_TOP*8 +: 8] = `CMB_FULL_MASK;
        sp.eng_wbytes[`CMB_SLOT_ID_LOW*8 +: 8] = eng_wr_id[7:0];
        sp.eng_wmask[`CMB_SLOT_ID_LOW*8 +: 8] = `CMB_FULL_MASK;
        sp.eng_wbytes[`CMB_SLOT_ID_LMID*8 +: 8] = eng_wr_id[15:8];
        sp.eng_wmask[`CMB_SLOT_ID_LMID*8 +: 8] = `CMB_FULL_MASK;
        // payload: byte one in the low lane of the engine word
        sp.eng_wbytes[`CMB_SLOT_DATA*8 +: 64] = eng_wr_data;
        sp.eng_wmask[`CMB_SLOT_DATA*8 +: 64] = '1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // engine read image: fields of a fetched mailbox
    assign sp.eng_ridx = s.eng_mbx;
    assign img = sp.eng_rbytes;
    assign img_code = img[`CMB_SLOT_LEN*8 +: 4];
    assign img_fmt = cmb_slot(img, `CMB_SLOT_FMT);
    // identifier from four bytes, most significant first
    assign img_id = {cmb_slot(img, `CMB_SLOT_ID_TOP), img_fmt[7:5], img_fmt[1:0],
        cmb_slot(img, `CMB_SLOT_ID_LMID), cmb_slot(img, `CMB_SLOT_ID_LOW)};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for the bus slave and the engine fetch pipeline
    always_comb
    begin
        next_s = s;

        // write channel: address and data in either order
        case (s.wst)
            CMB_W_IDLE:
            begin
                if (s.awready && awvalid)
                begin
                    next_s.aw_got = 1'b1;
                    next_s.waddr = awaddr;
                    next_s.awready = 1'b0;
                end
                else
                begin
                    next_s.awready = !s.aw_got;
                end
                if (s.wready && wvalid)
                begin
                    next_s.w_got = 1'b1;
                    next_s.wbyte = wdata[7:0];
                    next_s.wlane = wstrb[0];
                    next_s.wready = 1'b0;
                end
                else
                begin
                    next_s.wready = !s.w_got;
                end
                if (next_s.aw_got && next_s.w_got)
                begin
                    next_s.wst = CMB_W_STORE;
                end
            end
            CMB_W_STORE:
            begin
                // held while the engine owns the array
                if (!eng_wr_en)
                begin
                    next_s.bvalid = 1'b1;
                    next_s.bresp = waddr_ok ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
                    next_s.wst = CMB_W_RESP;
                end
            end
            CMB_W_RESP:
            begin
                if (bready)
                begin
                    next_s.bvalid = 1'b0;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    next_s.awready = 1'b1;
                    next_s.wready = 1'b1;
                    next_s.wst = CMB_W_IDLE;
                end
            end
            default:
            begin
                next_s.wst = CMB_W_IDLE;
            end
        endcase

        // read channel: one wait for the registered array read
        case (s.rst)
            CMB_R_IDLE:
            begin
                if (s.arready && arvalid)
                begin
                    next_s.raddr = araddr;
                    next_s.arready = 1'b0;
                    next_s.rst = CMB_R_WAIT;
                end
                else
                begin
                    next_s.arready = 1'b1;
                end
            end
            CMB_R_WAIT:
            begin
                next_s.rst = CMB_R_FETCH;
            end
            CMB_R_FETCH:
            begin
                // byte sits in the low lane, upper bits read as zero
                next_s.rdata = raddr_ok ? {24'h00_0000, sp.cpu_rdata} : 32'h0000_0000;
                next_s.rresp = raddr_ok ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
                next_s.rvalid = 1'b1;
                next_s.rst = CMB_R_RESP;
            end
            CMB_R_RESP:
            begin
                if (rready)
                begin
                    next_s.rvalid = 1'b0;
                    next_s.arready = 1'b1;
                    next_s.rst = CMB_R_IDLE;
                end
            end
            default:
            begin
                next_s.rst = CMB_R_IDLE;
            end
        endcase

        // engine fetch: request, array read, decode; fully pipelined
        if (eng_rd_req)
        begin
            next_s.eng_mbx = eng_rd_mbx;
        end
        next_s.eng_p1 = eng_rd_req;
        next_s.eng_p2 = s.eng_p1;
        next_s.eng_rd_valid = s.eng_p2;
        if (s.eng_p2)
        begin
            next_s.eng_rd_len = cmb_eff_len(img_code);
            next_s.eng_rd_rtr = img_fmt[`CMB_RTR_BIT];
            next_s.eng_rd_ide = img_fmt[`CMB_IDE_BIT];
            // standard frames carry only the top eleven identifier bits
            next_s.eng_rd_id = img_id;
            if (!img_fmt[`CMB_IDE_BIT])
            begin
                next_s.eng_rd_id[`CMB_STD_ID_LSB-1:0] = '0;
            end
            next_s.eng_rd_data = img[`CMB_SLOT_DATA*8 +: 64];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control state only; the mailbox bytes live in the array above
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= cmb_state_t'('0);
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign eng_rd_valid = s.eng_rd_valid;
    assign eng_rd_len = s.eng_rd_len;
    assign eng_rd_rtr = s.eng_rd_rtr;
    assign eng_rd_ide = s.eng_rd_ide;
    assign eng_rd_id = s.eng_rd_id;
    assign eng_rd_data = s.eng_rd_data;

endmodule : cmb_mailbox_ram

// File: sim/cmb_mailbox_ram_assertions.sv
/*
 * Port checks: bus handshakes, latencies, fetched fields.
 * Assumes one clock domain and a master that offers address and data together.
 */
`timescale 1ns/10ps

module cmb_ram_chk #(
    parameter int MBX_N = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic eng_rd_req,
    input wire logic eng_rd_valid,
    input wire cmb_pkg::cmb_len_t eng_rd_len,
    input wire logic eng_rd_ide,
    input wire cmb_pkg::cmb_id_t eng_rd_id,
    input wire logic eng_wr_en
);
    import cmb_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // handshake steps that open a transfer
    sequence aw_w_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence ar_take;
        arvalid && arready;
    endsequence
    sequence ar_far;
        ar_take ##0 (araddr[31:10] != 22'h00_0000);
    endsequence
    // an engine write may stall the store; only a quiet cycle bounds it
    wr_answer_a: assert property (aw_w_take ##1 !eng_wr_en |-> ##1 bvalid)
        else $error("write answer missing");
    wr_busy_a: assert property (aw_w_take |=> !awready && !wready)
        else $error("ready kept during write");
    wr_reopen_a: assert property (bvalid && bready |=> awready && wready && !bvalid)
        else $error("write channel not reopened");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    rd_latency_a: assert property (ar_take |=> !rvalid [*2] ##1 rvalid)
        else $error("read latency wrong");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    rd_byte_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("read upper bits set");
    rd_far_a: assert property (ar_far |-> ##3 rresp == 2'b10 && rdata == 32'h0000_0000)
        else $error("unmapped read answered");
    fetch_lat_a: assert property (eng_rd_req |-> ##3 eng_rd_valid)
        else $error("fetch latency wrong");
    len_clamp_a: assert property (eng_rd_valid |-> eng_rd_len <= 4'h8)
        else $error("fetched length above eight");
    std_id_a: assert property (eng_rd_valid && !eng_rd_ide |-> eng_rd_id[17:0] == 18'h0_0000)
        else $error("standard id low bits set");
endmodule : cmb_ram_chk

bind cmb_mailbox_ram cmb_ram_chk #(.MBX_N(MBX_N)) u_cmb_ram_chk (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .eng_rd_req, .eng_rd_valid, .eng_rd_len, .eng_rd_ide, .eng_rd_id,
    .eng_wr_en);

// File: sim/cmb_engine_model.sv
/*
 * Protocol engine stand-in: fetches and stores whole mailboxes.
 * Assumes its tasks are entered just after a rising edge of aclk.
 */
`timescale 1ns/10ps

module cmb_engine_model (
    input wire logic aclk,
    output logic eng_rd_req,
    output cmb_pkg::cmb_mbx_t eng_rd_mbx,
    input wire logic eng_rd_valid,
    input wire cmb_pkg::cmb_len_t eng_rd_len,
    input wire logic eng_rd_rtr,
    input wire logic eng_rd_ide,
    input wire cmb_pkg::cmb_id_t eng_rd_id,
    input wire cmb_pkg::cmb_payload_t eng_rd_data,
    output logic eng_wr_en,
    output cmb_pkg::cmb_mbx_t eng_wr_mbx,
    output cmb_pkg::cmb_len_t eng_wr_dlc,
    output logic eng_wr_rtr,
    output logic eng_wr_ide,
    output cmb_pkg::cmb_id_t eng_wr_id,
    output cmb_pkg::cmb_payload_t eng_wr_data
);
    import cmb_pkg::*;
    ////////////////////////////////////////////////////////////////
    // quiet at time zero
    initial
    begin
        {eng_rd_req, eng_rd_mbx, eng_wr_en, eng_wr_mbx, eng_wr_dlc, eng_wr_rtr} = '0;
        {eng_wr_ide, eng_wr_id, eng_wr_data} = '0;
    end
    // fields are scrambled outside the strobe: they mean nothing there
    task automatic put(input cmb_mbx_t m, input logic [98:0] f);
        eng_wr_en <= 1'b1;
        eng_wr_mbx <= m;
        {eng_wr_dlc, eng_wr_rtr, eng_wr_ide, eng_wr_id, eng_wr_data} <= f;
        @(posedge aclk);
        eng_wr_en <= 1'b0;
        eng_wr_mbx <= ~m;
        {eng_wr_dlc, eng_wr_rtr, eng_wr_ide, eng_wr_id, eng_wr_data} <= ~f;
    endtask : put
    // one fetch; the answer is awaited at most eight edges
    task automatic get(input cmb_mbx_t m, output logic [98:0] f);
        int n;
        eng_rd_req <= 1'b1;
        eng_rd_mbx <= m;
        @(posedge aclk);
        eng_rd_req <= 1'b0;
        eng_rd_mbx <= ~m;
        f = 'x;
        n = 0;
        while (n < 8)
        begin
            @(posedge aclk);
            n++;
            if (eng_rd_valid)
            begin
                f = {eng_rd_len, eng_rd_rtr, eng_rd_ide, eng_rd_id, eng_rd_data};
                n = 8;
            end
        end
    endtask : get
endmodule : cmb_engine_model

// File: sim/tb_top.sv
/*
 * Self-checking bench: register port, engine port, reset.
 * Assumes the engine model and checker are compiled alongside.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin n_checks++; if ((g) !== (e)) \
    begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
    import cmb_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, eng_rd_req, eng_rd_valid, eng_rd_rtr, eng_rd_ide;
    logic eng_wr_en, eng_wr_rtr, eng_wr_ide;
    logic [31:0] awaddr, wdata, araddr, rdata, j, rd32;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    cmb_mbx_t eng_rd_mbx, eng_wr_mbx;
    cmb_len_t eng_rd_len, eng_wr_dlc;
    cmb_id_t eng_rd_id, eng_wr_id;
    cmb_payload_t eng_rd_data, eng_wr_data;
    cmb_byte_t sh [16][16];
    logic [98:0] fr;
    logic [127:0] rr;
    integer seed = 32'h6846_0ad6;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int mm;
    ////////////////////////////////////////////////////////////////
    cmb_mailbox_ram u_cmb_mailbox_ram (.aclk, .aresetn, .awaddr, .awprot(3'b000), .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'b000), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .eng_rd_req,
        .eng_rd_mbx, .eng_rd_valid, .eng_rd_len, .eng_rd_rtr, .eng_rd_ide, .eng_rd_id,
        .eng_rd_data, .eng_wr_en, .eng_wr_mbx, .eng_wr_dlc, .eng_wr_rtr, .eng_wr_ide,
        .eng_wr_id, .eng_wr_data);
    cmb_engine_model u_cmb_engine_model (.aclk, .eng_rd_req, .eng_rd_mbx, .eng_rd_valid,
        .eng_rd_len, .eng_rd_rtr, .eng_rd_ide, .eng_rd_id, .eng_rd_data, .eng_wr_en,
        .eng_wr_mbx, .eng_wr_dlc, .eng_wr_rtr, .eng_wr_ide, .eng_wr_id, .eng_wr_data);
    // clock and watchdog; the run needs far fewer cycles
    initial aclk = 1'b0;
    always #20 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    // byte address: mailbox in bits 9:6, slot in bits 5:2
    function automatic logic [31:0] ad(input int m, input int k);
        ad = {22'h00_0000, m[3:0], k[3:0], 2'b00};
    endfunction : ad
    // fields the engine should see for mailbox m
    function automatic logic [98:0] x_frame(input int m);
        cmb_id_t id;
        logic [63:0] d;
        id = {sh[m][5], sh[m][4][7:5], sh[m][4][1:0], sh[m][7], sh[m][6]};
        if (!sh[m][4][3])
            id[17:0] = 18'h0_0000;
        for (int k = 0; k < 8; k++)
            d[k*8 +: 8] = sh[m][8+k];
        x_frame = {(sh[m][0][3:0] > 4'h8) ? 4'h8 : sh[m][0][3:0], sh[m][4][4], sh[m][4][3], id, d};
    endfunction : x_frame
    // one write; each channel is released at the edge that takes it
    task automatic wr(input logic [31:0] a, input cmb_byte_t d, input logic s);
        logic done;
        j = $random(seed);
        awaddr <= a;
        wdata <= {j[31:8], d};
        wstrb <= {j[3:1], s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                rsp = bresp;
                done = 1'b1;
            end
        end
    endtask : wr
    // one read; answer taken at its handshake edge
    task automatic rd(input logic [31:0] a);
        logic done;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rd32 = rdata;
                rsp = rresp;
                done = 1'b1;
            end
        end
    endtask : rd
    // read back a whole mailbox and fetch it through the engine
    task automatic mbx_chk(input int m);
        for (int k = 0; k < 16; k++)
        begin
            rd(ad(m, k));
            `CHK("rdata", {24'h00_0000, sh[m][k]}, rd32)
            `CHK("rresp", 2'b00, rsp)
        end
        repeat ({$random(seed)} % 3) @(posedge aclk);
        u_cmb_engine_model.get(m[3:0], fr);
        `CHK("fetch", x_frame(m), fr)
    endtask : mbx_chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // every byte written; slot 0 of mailbox m gets length code m
        for (int m = 0; m < 16; m++)
            for (int k = 0; k < 16; k++)
            begin
                j = $random(seed);
                if (k == 0)
                    j[3:0] = m[3:0];
                sh[m][k] = j[7:0];
                wr(ad(m, k), j[7:0], 1'b1);
                `CHK("bresp", 2'b00, rsp)
            end
        wr(ad(3, 9), ~sh[3][9], 1'b0);
        for (int m = 0; m < 16; m++)
            mbx_chk(m);
        $display("test registers done");
        // engine stores race a cpu store; odd rounds stall the bus write
        for (int i = 0; i < 6; i++)
        begin
            rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
            fr = rr[98:0];
            mm = rr[127:124];
            j = $random(seed);
            sh[mm ^ 1][8] = j[7:0];
            fork
                wr(ad(mm ^ 1, 8), sh[mm ^ 1][8], 1'b1);
                begin
                    repeat (i % 2) @(posedge aclk);
                    u_cmb_engine_model.put(mm[3:0], fr);
                end
            join
            sh[mm][0][3:0] = fr[98:95];
            sh[mm][4] = {fr[84:82], fr[94], fr[93], sh[mm][4][2], fr[81:80]};
            sh[mm][5] = fr[92:85];
            sh[mm][6] = fr[71:64];
            sh[mm][7] = fr[79:72];
            for (int k = 0; k < 8; k++)
                sh[mm][8+k] = fr[k*8 +: 8];
            mbx_chk(mm);
            mbx_chk(mm ^ 1);
        end
        $display("test engine done");
        // addresses past the map are refused without a store
        for (int i = 0; i < 2; i++)
        begin
            wr(i ? 32'h8000_0000 : 32'h0000_0400, 8'hA5, 1'b1);
            `CHK("far bresp", 2'b10, rsp)
            rd(i ? 32'h8000_0000 : 32'h0000_0400);
            `CHK("far rresp", 2'b10, rsp)
            `CHK("far rdata", 32'h0000_0000, rd32)
        end
        mbx_chk(0);
        $display("test unmapped done");
        // a reset in mid-run leaves the stored bytes alone
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        mbx_chk(5);
        mbx_chk(15);
        $display("test reset done");
        close_out;
    end
endmodule : tb_top
